// ==== rtl/led_ctrl_pkg.sv ====
// package for the led sink protection and power control block
// assumes a single 100 MHz clock and an AHB-Lite register bus
package led_ctrl_pkg;
    // channel organisation
    localparam int unsigned CHANNELS      = 48;
    localparam int unsigned GROUPS        = 12;
    // register byte offsets
    localparam logic [7:0] OFF_FC_FIRST   = 8'h00;
    localparam logic [7:0] OFF_FC_SECOND  = 8'h04;
    localparam logic [7:0] OFF_CC_RED     = 8'h08;
    localparam logic [7:0] OFF_CC_GREEN   = 8'h0C;
    localparam logic [7:0] OFF_CC_BLUE    = 8'h10;
    localparam logic [7:0] OFF_STATUS     = 8'h14;
    localparam logic [7:0] OFF_IRQ_STAT   = 8'h18;
    localparam logic [7:0] OFF_IRQ_MASK   = 8'h1C;
    localparam logic [7:0] OFF_OPEN_LO    = 8'h20;
    localparam logic [7:0] OFF_OPEN_HI    = 8'h24;
    // fields of the first function control register
    localparam int unsigned BC_POS        = 0;
    localparam int unsigned THR_POS       = 4;
    // fields of the second function control register
    localparam int unsigned PSAVE_POS     = 5;
    // reset values
    localparam logic [2:0] BC_RESET       = 3'h4;
    localparam logic [8:0] CC_RESET       = 9'h100;
    localparam logic [1:0] THR_RESET      = 2'h0;
    // status / interrupt bit positions
    localparam int unsigned EV_TEMP       = 0;
    localparam int unsigned EV_REF        = 1;
    localparam int unsigned EV_PSAVE      = 2;
    localparam int unsigned EV_OPEN       = 3;
    localparam int unsigned EV_BITS       = 4;
    // group stagger delay in clock cycles
    localparam int unsigned STAGGER_CYCLES = 4;

    // protection indications after synchronising
    typedef struct packed {
        logic temp;
        logic ref_low;
    } protect_s;

    typedef enum logic [1:0] {
        ST_NORMAL,
        ST_SAVE
    } power_e;
endpackage

// ==== rtl/led_sink_protection_power_control.sv ====
// top of led sink protection and power control, with AHB-Lite registers
// assumes comparators and protection flags arrive asynchronously from analog
//
// Functional notes
// - open flag is 1 while output voltage sits below selected threshold, else 0
// - comparator result is used only during that channel's on period
// - open flag reads 0 for every output that is currently off; this block clears it only while CHANNEL_ON_I is low or in power save
// - power save enable is bit 5 of second function control, reset 0
// - enter power save on frame sync when enabled and next frame all zero
// - leave power save as soon as any non-zero grayscale arrives
// - power save holds current outputs and open detection disabled
// - pre-charge pull-up is on exactly during common-line switching
// - over-temperature indication turns all outputs off until it clears; here they stay off after it clears until the next first pwm edge
// - reference-low indication turns all outputs off until it clears; here they stay off after it clears until the next first pwm edge
// - twelve output groups switch on one after another at first pwm edge
// - global brightness code resets to 4h and applies immediately
// - each color group brightness code resets to 100h
//
// The register addresses and the AHB-Lite interface to the registers were decided locally.
module led_sink_protection_power_control
    import led_ctrl_pkg::*;
#(
    parameter int unsigned NCH = CHANNELS
) (
    // clock and reset
    input  wire logic                 CLOCK_I,
    input  wire logic                 RSTN_I,
    // ahb-lite slave
    input  wire logic                 HSEL_I,
    input  wire logic [31:0]          HADDR_I,
    input  wire logic [1:0]           HTRANS_I,
    input  wire logic                 HWRITE_I,
    input  wire logic [2:0]           HSIZE_I,
    input  wire logic [31:0]          HWDATA_I,
    input  wire logic                 HREADY_I,
    output logic      [31:0]          HRDATA_O,
    output logic                      HREADYOUT_O,
    output logic                      HRESP_O,
    // display data events
    input  wire logic                 FRAME_SYNC_I,
    input  wire logic                 GS_VALID_I,
    input  wire logic                 GS_NONZERO_I,
    input  wire logic                 PWM_FIRST_EDGE_I,
    input  wire logic                 LINE_SWITCH_I,
    input  wire logic [NCH-1:0]       CHANNEL_ON_I,
    // analog indications
    input  wire logic [NCH-1:0]       BELOW_THR_I,
    input  wire logic                 OVER_TEMP_I,
    input  wire logic                 REF_LOW_I,
    // outputs to the analog core
    output logic      [NCH-1:0]       SINK_ENABLE_O,
    output logic      [NCH-1:0]       PRECHARGE_O,
    output logic                      DETECT_ENABLE_O,
    output logic      [1:0]           THRESHOLD_SEL_O,
    output logic      [2:0]           BRIGHT_CODE_O,
    output logic      [26:0]          COLOR_CODE_O,
    output logic      [NCH-1:0]       OPEN_LED_O,
    output logic                      POWER_SAVE_O,
    output logic                      IRQ_O
);
    localparam int unsigned PER_GRP = NCH / GROUPS;
    localparam int unsigned CNT_W   = $clog2(STAGGER_CYCLES + 1);

    initial begin
        if (NCH % GROUPS != 0 || NCH < GROUPS || NCH > 64)
            $error("NCH must be a multiple of twelve and at most 64");
    end

    // reset release through two flops
    logic rst_meta, rst_n;
    always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // two-stage synchronisers for analog indications
    logic [NCH+1:0] sync_a, sync_b;
    always_ff @(posedge CLOCK_I or negedge rst_n) begin
        if (!rst_n) begin
            sync_a <= '0;
            sync_b <= '0;
        end else begin
            sync_a <= {OVER_TEMP_I, REF_LOW_I, BELOW_THR_I};
            sync_b <= sync_a;
        end
    end
    protect_s       prot;
    logic [NCH-1:0] below;
    assign prot  = protect_s'(sync_b[NCH+1:NCH]);
    assign below = sync_b[NCH-1:0];

    // register storage
    logic [2:0]          bright;
    logic [1:0]          thr_sel;
    logic                psave_en;
    logic [8:0]          cc_r, cc_g, cc_b;
    logic [EV_BITS-1:0]  irq_stat, irq_mask;
    power_e              pstate;
    logic [NCH-1:0]      open_flag;
    logic [3:0]          grp_on;
    logic [CNT_W-1:0]    stag_cnt;
    logic                stagger_run;

    // ahb address phase capture
    logic       ph_valid, ph_write;
    logic [7:0] ph_addr;
    logic       take;
    assign take = HSEL_I && HREADY_I && HTRANS_I[1];
    always_ff @(posedge CLOCK_I or negedge rst_n) begin
        if (!rst_n) begin
            ph_valid <= 1'b0;
            ph_write <= 1'b0;
            ph_addr  <= 8'h00;
        end else if (HREADY_I) begin
            ph_valid <= take;
            ph_write <= HWRITE_I;
            ph_addr  <= HADDR_I[7:0];
        end
    end
    logic wr;
    assign wr          = ph_valid && ph_write;
    assign HRESP_O     = 1'b0;

    // a read waits one cycle so a write landing just before it is seen
    logic rd_wait, rd_done;
    assign rd_wait     = ph_valid && !ph_write && !rd_done;
    assign HREADYOUT_O = !rd_wait;
    always_ff @(posedge CLOCK_I or negedge rst_n) begin
        if (!rst_n)
            rd_done <= 1'b0;
        else
            rd_done <= rd_wait;
    end

    // software writable control registers
    always_ff @(posedge CLOCK_I or negedge rst_n) begin
        if (!rst_n) begin
            bright   <= BC_RESET;
            thr_sel  <= THR_RESET;
            psave_en <= 1'b0;
            cc_r     <= CC_RESET;
            cc_g     <= CC_RESET;
            cc_b     <= CC_RESET;
            irq_mask <= '0;
        end else if (wr) begin
            case (ph_addr)
                OFF_FC_FIRST: begin
                    bright  <= HWDATA_I[BC_POS +: 3];
                    thr_sel <= HWDATA_I[THR_POS +: 2];
                end
                OFF_FC_SECOND: psave_en <= HWDATA_I[PSAVE_POS];
                OFF_CC_RED:    cc_r     <= HWDATA_I[8:0];
                OFF_CC_GREEN:  cc_g     <= HWDATA_I[8:0];
                OFF_CC_BLUE:   cc_b     <= HWDATA_I[8:0];
                OFF_IRQ_MASK:  irq_mask <= HWDATA_I[EV_BITS-1:0];
                default: ;
            endcase
        end
    end

    // read mux, registered into the data phase
    logic [31:0] rdata;
    always_comb begin
        rdata = 32'h0000_0000;
        case (ph_addr)
            OFF_FC_FIRST:  rdata = {26'h0, thr_sel, 1'b0, bright};
            OFF_FC_SECOND: rdata = {26'h0, psave_en, 5'h00};
            OFF_CC_RED:    rdata = {23'h0, cc_r};
            OFF_CC_GREEN:  rdata = {23'h0, cc_g};
            OFF_CC_BLUE:   rdata = {23'h0, cc_b};
            OFF_STATUS:    rdata = {28'h0, |open_flag, pstate == ST_SAVE, prot.ref_low,
                                    prot.temp};
            OFF_IRQ_STAT:  rdata = {28'h0, irq_stat};
            OFF_IRQ_MASK:  rdata = {28'h0, irq_mask};
            OFF_OPEN_LO:   rdata = 32'(open_flag);
            OFF_OPEN_HI:   rdata = 32'({64'(open_flag)} >> 32);
            default:       rdata = 32'h0000_0000;
        endcase
    end
    // read data captured in the wait cycle, held through the ready cycle
    always_ff @(posedge CLOCK_I or negedge rst_n) begin
        if (!rst_n)
            HRDATA_O <= 32'h0000_0000;
        else if (rd_wait)
            HRDATA_O <= rdata;
    end

    // power save state machine
    always_ff @(posedge CLOCK_I or negedge rst_n) begin
        if (!rst_n) begin
            pstate <= ST_NORMAL;
        end else begin
            case (pstate)
                ST_NORMAL:
                    if (FRAME_SYNC_I && psave_en && !GS_NONZERO_I)
                        pstate <= ST_SAVE;
                ST_SAVE:
                    if (GS_VALID_I && GS_NONZERO_I)
                        pstate <= ST_NORMAL;
                default: pstate <= ST_NORMAL;
            endcase
        end
    end
    logic outputs_off;
    assign outputs_off = (pstate == ST_SAVE) || prot.temp || prot.ref_low;

    // staggered group turn-on after the first pwm edge
    // any shutdown drops every group; the next frame's first edge restarts them
    always_ff @(posedge CLOCK_I or negedge rst_n) begin
        if (!rst_n) begin
            grp_on      <= 4'h0;
            stag_cnt    <= '0;
            stagger_run <= 1'b0;
        end else if (outputs_off) begin
            grp_on      <= 4'h0;
            stagger_run <= 1'b0;
        end else if (PWM_FIRST_EDGE_I && !stagger_run) begin
            grp_on      <= 4'h1;
            stag_cnt    <= '0;
            stagger_run <= 1'b1;
        end else if (stagger_run && grp_on < 4'(GROUPS)) begin
            if (stag_cnt == CNT_W'(STAGGER_CYCLES - 1)) begin
                stag_cnt <= '0;
                grp_on   <= grp_on + 4'h1;
            end else begin
                stag_cnt <= stag_cnt + CNT_W'(1);
            end
        end
    end

    // per-channel sink enable, pre-charge and open flag
    genvar ch;
    generate
        for (ch = 0; ch < NCH; ch++) begin : g_ch
            localparam logic [3:0] GIDX = 4'(ch / PER_GRP);
            always_ff @(posedge CLOCK_I or negedge rst_n) begin
                if (!rst_n) begin
                    SINK_ENABLE_O[ch] <= 1'b0;
                    PRECHARGE_O[ch]   <= 1'b0;
                    open_flag[ch]     <= 1'b0;
                end else begin
                    SINK_ENABLE_O[ch] <= !outputs_off && (grp_on > GIDX)
                                         && CHANNEL_ON_I[ch];
                    PRECHARGE_O[ch]   <= LINE_SWITCH_I;
                    if (!CHANNEL_ON_I[ch] || pstate == ST_SAVE)
                        open_flag[ch] <= 1'b0;
                    else
                        open_flag[ch] <= below[ch];
                end
            end
        end
    endgenerate

    // sticky interrupt status, set wins over write-one clear
    logic [EV_BITS-1:0] ev, clr;
    assign ev  = {|open_flag, pstate == ST_SAVE, prot.ref_low, prot.temp};
    assign clr = (wr && ph_addr == OFF_IRQ_STAT) ? HWDATA_I[EV_BITS-1:0] : '0;
    always_ff @(posedge CLOCK_I or negedge rst_n) begin
        if (!rst_n)
            irq_stat <= '0;
        else
            irq_stat <= (irq_stat & ~clr) | ev;
    end

    // outputs to the analog core
    always_ff @(posedge CLOCK_I or negedge rst_n) begin
        if (!rst_n) begin
            DETECT_ENABLE_O <= 1'b0;
            THRESHOLD_SEL_O <= THR_RESET;
            BRIGHT_CODE_O   <= BC_RESET;
            COLOR_CODE_O    <= {CC_RESET, CC_RESET, CC_RESET};
            IRQ_O           <= 1'b0;
        end else begin
            DETECT_ENABLE_O <= (pstate != ST_SAVE);
            THRESHOLD_SEL_O <= thr_sel;
            BRIGHT_CODE_O   <= bright;
            COLOR_CODE_O    <= {cc_b, cc_g, cc_r};
            IRQ_O           <= |(irq_stat & irq_mask);
        end
    end
    assign OPEN_LED_O   = open_flag;
    assign POWER_SAVE_O = (pstate == ST_SAVE);

    // checks, sampled on the block clock and idle while reset is held
    a_open_off_zero: assert property (@(posedge CLOCK_I) disable iff (!rst_n)
        !CHANNEL_ON_I[0] |=> !open_flag[0])
        else $error("open flag set while off");
    a_open_follow: assert property (@(posedge CLOCK_I) disable iff (!rst_n)
        (CHANNEL_ON_I[0] && pstate == ST_NORMAL) |=> open_flag[0] == $past(below[0]))
        else $error("open flag does not follow comparator");
    a_psave_enter: assert property (@(posedge CLOCK_I) disable iff (!rst_n)
        (pstate == ST_NORMAL && FRAME_SYNC_I && psave_en && !GS_NONZERO_I)
        |=> pstate == ST_SAVE)
        else $error("power save not entered");
    a_psave_leave: assert property (@(posedge CLOCK_I) disable iff (!rst_n)
        (pstate == ST_SAVE && GS_VALID_I && GS_NONZERO_I) |=> pstate == ST_NORMAL)
        else $error("power save not left");
    a_psave_off: assert property (@(posedge CLOCK_I) disable iff (!rst_n)
        pstate == ST_SAVE |=> SINK_ENABLE_O == '0)
        else $error("sinks on in save");
    a_detect_save: assert property (@(posedge CLOCK_I) disable iff (!rst_n)
        pstate == ST_SAVE |=> !DETECT_ENABLE_O && OPEN_LED_O == '0)
        else $error("detection active in save");
    a_temp_off: assert property (@(posedge CLOCK_I) disable iff (!rst_n)
        prot.temp |=> SINK_ENABLE_O == '0)
        else $error("sinks on when hot");
    a_ref_off: assert property (@(posedge CLOCK_I) disable iff (!rst_n)
        prot.ref_low |=> SINK_ENABLE_O == '0)
        else $error("sinks on at ref low");
    a_precharge: assert property (@(posedge CLOCK_I) disable iff (!rst_n)
        LINE_SWITCH_I |=> PRECHARGE_O == '1)
        else $error("pre-charge missing");
    a_precharge_rel: assert property (@(posedge CLOCK_I) disable iff (!rst_n)
        !LINE_SWITCH_I |=> PRECHARGE_O == '0)
        else $error("pre-charge held outside switching");
    a_stagger_first: assert property (@(posedge CLOCK_I) disable iff (!rst_n)
        (PWM_FIRST_EDGE_I && !stagger_run && !outputs_off) |=> grp_on == 4'h1)
        else $error("first group not started");
    a_stagger_step: assert property (@(posedge CLOCK_I) disable iff (!rst_n)
        (grp_on != $past(grp_on) && grp_on > 4'h1)
        |-> $past(stag_cnt) == CNT_W'(STAGGER_CYCLES - 1))
        else $error("group step spacing wrong");
    a_irq_level: assert property (@(posedge CLOCK_I) disable iff (!rst_n)
        |(irq_stat & irq_mask) |=> IRQ_O)
        else $error("interrupt output missing");
    a_read_data: assert property (@(posedge CLOCK_I) disable iff (!rst_n)
        (ph_valid && !ph_write && rd_done) |-> HRDATA_O == $past(rdata))
        else $error("read data not from addressed register");

    // cover points for the main scenarios
    c_enter_save: cover property (@(posedge CLOCK_I) disable iff (!rst_n)
        pstate == ST_NORMAL ##1 pstate == ST_SAVE);
    c_leave_save: cover property (@(posedge CLOCK_I) disable iff (!rst_n)
        pstate == ST_SAVE ##1 pstate == ST_NORMAL);
    c_all_groups: cover property (@(posedge CLOCK_I) disable iff (!rst_n)
        grp_on == 4'(GROUPS));
    c_protect_off: cover property (@(posedge CLOCK_I) disable iff (!rst_n)
        prot.temp || prot.ref_low);
    c_irq: cover property (@(posedge CLOCK_I) disable iff (!rst_n) IRQ_O);
endmodule // led_sink_protection_power_control

// ==== verif/led_matrix_model.sv ====
// model of the led matrix on the sink outputs, with its comparators
// assumes one clock shared with the block; bench chooses open leds
module led_matrix_model
    import led_ctrl_pkg::*;
(
    // clock
    input  wire logic                clk_i,
    // state from the bench
    input  wire logic [CHANNELS-1:0] channel_on_i,
    input  wire logic [CHANNELS-1:0] open_mask_i,
    // comparator results
    output logic      [CHANNELS-1:0] below_thr_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [CHANNELS-1:0] noise = 48'h5A3C_96E1_0F7B;

    // free-running pattern, stands in for a floating comparator
    always_ff @(posedge clk_i) begin
        noise <= {noise[CHANNELS-2:0], ~^noise[CHANNELS-1:CHANNELS-4]};
    end

    // open string reads low while on; garbage while the sink is off
    assign below_thr_o = (channel_on_i & open_mask_i) | (~channel_on_i & noise);
endmodule // led_matrix_model

// ==== verif/test_led_sink_protection_power_control.sv ====
// self-checking bench for the led sink protection and power control block
// assumes 100 MHz clock, AHB-Lite master in the bench, matrix model beside
module test_led_sink_protection_power_control
    import led_ctrl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic CLOCK_I = 0, RSTN_I = 0, HSEL_I = 0, HWRITE_I = 0, FRAME_SYNC_I = 0;
    logic GS_VALID_I = 0, GS_NONZERO_I = 0, PWM_FIRST_EDGE_I = 0, LINE_SWITCH_I = 0;
    logic OVER_TEMP_I = 0, REF_LOW_I = 0, HREADYOUT_O, HRESP_O, DETECT_ENABLE_O;
    logic POWER_SAVE_O, IRQ_O;
    logic [31:0] HADDR_I = '0, HWDATA_I = '0, HRDATA_O;
    logic [1:0]  HTRANS_I = '0, THRESHOLD_SEL_O;
    logic [2:0]  HSIZE_I = 3'h2, BRIGHT_CODE_O;
    logic [26:0] COLOR_CODE_O;
    logic [CHANNELS-1:0] CHANNEL_ON_I = '0, open_mask = '0, BELOW_THR_I;
    logic [CHANNELS-1:0] SINK_ENABLE_O, PRECHARGE_O, OPEN_LED_O;
    int miscompares = 0, n_tests = 0;

    // design under test
    led_sink_protection_power_control #(.NCH(CHANNELS)) u_led_sink_protection_power_control (
        .CLOCK_I(CLOCK_I), .RSTN_I(RSTN_I), .HSEL_I(HSEL_I), .HADDR_I(HADDR_I),
        .HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I), .HSIZE_I(HSIZE_I), .HWDATA_I(HWDATA_I),
        .HREADY_I(HREADYOUT_O), .HRDATA_O(HRDATA_O), .HREADYOUT_O(HREADYOUT_O),
        .HRESP_O(HRESP_O), .FRAME_SYNC_I(FRAME_SYNC_I), .GS_VALID_I(GS_VALID_I),
        .GS_NONZERO_I(GS_NONZERO_I), .PWM_FIRST_EDGE_I(PWM_FIRST_EDGE_I),
        .LINE_SWITCH_I(LINE_SWITCH_I), .CHANNEL_ON_I(CHANNEL_ON_I),
        .BELOW_THR_I(BELOW_THR_I), .OVER_TEMP_I(OVER_TEMP_I), .REF_LOW_I(REF_LOW_I),
        .SINK_ENABLE_O(SINK_ENABLE_O), .PRECHARGE_O(PRECHARGE_O),
        .DETECT_ENABLE_O(DETECT_ENABLE_O), .THRESHOLD_SEL_O(THRESHOLD_SEL_O),
        .BRIGHT_CODE_O(BRIGHT_CODE_O), .COLOR_CODE_O(COLOR_CODE_O),
        .OPEN_LED_O(OPEN_LED_O), .POWER_SAVE_O(POWER_SAVE_O), .IRQ_O(IRQ_O));

    // led matrix and comparators
    led_matrix_model u_led_matrix_model (
        .clk_i(CLOCK_I), .channel_on_i(CHANNEL_ON_I), .open_mask_i(open_mask),
        .below_thr_o(BELOW_THR_I));

    // 100 MHz clock
    initial begin
        forever #5 CLOCK_I = ~CLOCK_I;
    end

    // expected open flags: only lit channels can report
    function automatic logic [63:0] exp_open(input logic [CHANNELS-1:0] on, mask);
        return 64'(on & mask);
    endfunction

    task automatic tick(input int n);
        repeat (n) @(posedge CLOCK_I);
    endtask

    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic final_report();
        $display("checks=%0d mismatches=%0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // one edge, then wait for ready under a bound
    task automatic edge_ready();
        int i;
        @(posedge CLOCK_I);
        for (i = 0; i < 50 && HREADYOUT_O !== 1'b1; i++) @(posedge CLOCK_I);
        if (i == 50) begin
            miscompares++;
            final_report();
        end
    endtask

    // single word transfer: address phase, then data phase
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        @(posedge CLOCK_I);
        HSEL_I   <= 1'b1;
        HTRANS_I <= 2'h2;
        HADDR_I  <= {24'h0, a};
        HWRITE_I <= w;
        edge_ready();
        HTRANS_I <= 2'h0;
        HWDATA_I <= wd;
        edge_ready();
        rd = HRDATA_O;
        HSEL_I <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
        tick(2);
    endtask

    // next frame's first pwm edge, then room for all groups to come on
    task automatic restart();
        PWM_FIRST_EDGE_I <= 1'b1;
        tick(1);
        PWM_FIRST_EDGE_I <= 1'b0;
        tick(50);
    endtask

    // main sequence
    initial begin
        logic [31:0] rd;
        logic [63:0] v;
        int t0, last, steps;
        void'($urandom(22));
        tick(2);
        RSTN_I <= 1'b1;
        tick(5);
        check(BRIGHT_CODE_O, BC_RESET);
        check(COLOR_CODE_O, {3{CC_RESET}});
        check(POWER_SAVE_O, 0);
        bus(1'b0, OFF_FC_SECOND, 0, rd);
        check(rd[PSAVE_POS], 0);
        bus(1'b0, 8'h40, 0, rd);
        check(rd, 0);
        check(HRESP_O, 0);
        $display("test reset done");
        // staggered turn-on, counted group by group
        CHANNEL_ON_I <= '1;
        PWM_FIRST_EDGE_I <= 1'b1;
        tick(1);
        PWM_FIRST_EDGE_I <= 1'b0;
        last = 0;
        t0 = -1;
        steps = 0;
        for (int c = 0; c < 100; c++) begin
            tick(1);
            if ($countones(SINK_ENABLE_O) != last) begin
                check(64'($countones(SINK_ENABLE_O) - last), CHANNELS / GROUPS);
                if (t0 >= 0) check(64'(c - t0), STAGGER_CYCLES);
                t0 = c;
                last = $countones(SINK_ENABLE_O);
                steps++;
            end
        end
        check(64'(steps), GROUPS);
        $display("test stagger done");
        // open flags with random lit channels, noisy comparators when off
        for (int k = 0; k < 6; k++) begin
            v = {$urandom, $urandom};
            CHANNEL_ON_I <= (k == 0) ? '1 : (k == 1) ? '0 : v[47:0];
            v = {$urandom, $urandom};
            open_mask <= (k < 2) ? '1 : v[47:0];
            v = $urandom;
            wr(OFF_FC_FIRST, {26'h0, v[5:4], 1'b0, v[2:0]});
            check(BRIGHT_CODE_O, v[2:0]);
            check(THRESHOLD_SEL_O, v[5:4]);
            bus(1'b0, OFF_FC_FIRST, 0, rd);
            check(rd, {26'h0, v[5:4], 1'b0, v[2:0]});
            tick(4);
            check(OPEN_LED_O, exp_open(CHANNEL_ON_I, open_mask));
            bus(1'b0, OFF_OPEN_LO, 0, rd);
            check(rd, exp_open(CHANNEL_ON_I, open_mask) & 64'hFFFF_FFFF);
            bus(1'b0, OFF_OPEN_HI, 0, rd);
            check(rd, exp_open(CHANNEL_ON_I, open_mask) >> 32);
        end
        for (int k = 0; k < 3; k++) begin
            v = $urandom;
            wr(OFF_CC_RED + 8'(4 * k), {23'h0, v[8:0]});
            check(COLOR_CODE_O[9*k +: 9], v[8:0]);
        end
        $display("test open and codes done");
        // pre-charge follows the switching interval
        for (int k = 0; k < 8; k++) begin
            LINE_SWITCH_I <= k[0];
            tick(2 + $urandom_range(3));
            check(PRECHARGE_O, {CHANNELS{k[0]}});
        end
        $display("test precharge done");
        // protection shutdown and resume, masked then unmasked
        CHANNEL_ON_I <= '1;
        open_mask <= '0;
        tick(6);
        wr(OFF_IRQ_MASK, 0);
        wr(OFF_IRQ_STAT, 32'hF);
        for (int k = 0; k < 4; k++) begin
            if (k == 2) wr(OFF_IRQ_MASK, 32'hF);
            if (k[0]) REF_LOW_I <= 1'b1;
            else OVER_TEMP_I <= 1'b1;
            tick(2);
            check(SINK_ENABLE_O, {CHANNELS{1'b1}});
            tick(4);
            check(SINK_ENABLE_O, 0);
            check(IRQ_O, 64'(k >= 2));
            OVER_TEMP_I <= 1'b0;
            REF_LOW_I <= 1'b0;
            tick(8);
            restart();
            check(SINK_ENABLE_O, {CHANNELS{1'b1}});
            wr(OFF_IRQ_STAT, 32'hF);
            check(IRQ_O, 0);
        end
        $display("test protection done");
        // power save entry at frame sync, exit on non-zero data
        open_mask <= '1;
        for (int k = 0; k < 4; k++) begin
            if (k == 1) wr(OFF_FC_SECOND, 32'h20);
            GS_NONZERO_I <= (k == 1);
            FRAME_SYNC_I <= 1'b1;
            tick(1);
            FRAME_SYNC_I <= 1'b0;
            tick(2);
            check(POWER_SAVE_O, 64'(k >= 2));
        end
        tick(4);
        check(SINK_ENABLE_O, 0);
        check(DETECT_ENABLE_O, 0);
        check(OPEN_LED_O, 0);
        GS_NONZERO_I <= 1'b1;
        GS_VALID_I <= 1'b1;
        tick(1);
        GS_VALID_I <= 1'b0;
        tick(2);
        check(POWER_SAVE_O, 0);
        tick(6);
        check(DETECT_ENABLE_O, 1);
        restart();
        check(SINK_ENABLE_O, {CHANNELS{1'b1}});
        $display("test power save done");
        final_report();
    end
endmodule // test_led_sink_protection_power_control
